// >>> dv/pps_far_model.sv
// Far side model: external timer clock pins and the pads outside the block
`timescale 1ns/1ps
module pps_far_model (
  // Clock and clock pin control
  input wire i_clk,
  input wire i_run,
  input wire [2:0] i_lvl,
  // Pads, ports A B C E H I packed high to low
  input wire [47:0] i_out,
  input wire [47:0] i_oe,
  input wire [47:0] i_pat,
  // Levels seen by the block
  output wire [2:0] o_tclk,
  output wire [47:0] o_in
);
  logic [2:0] cnt_q = 3'h0;

  ////////////////////////////////////////////////////////////////////////
  // Clock pins run at three rates only while enabled, else stand still
  always @(posedge i_clk) begin
    if (i_run) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
  assign o_tclk = i_run ? cnt_q : i_lvl;

  // A driven pad shows the block's value, an idle pad the outside level
  assign o_in = (i_oe & i_out) | (~i_oe & i_pat);
endmodule

// >>> dv/pps_monitor.sv
// Concurrent checks on the pin select block ports
`timescale 1ns/1ps
`include "pps_consts.vh"
module pps_monitor (
  // Clock, reset and register port
  input wire I_MCLK,
  input wire I_SYS_RST,
  input wire [7:0] I_ADDR,
  input wire [31:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  input wire [31:0] O_RDATA,
  // Timer clocks
  input wire I_EXT_TIMER_CLOCK_PIN_A,
  input wire I_EXT_TIMER_CLOCK_PIN_B,
  input wire I_EXT_TIMER_CLOCK_PIN_C,
  input wire O_PULSE_WIDTH_TIMER_CLK,
  input wire O_TIMER_MODULE_A_CLK,
  input wire O_TIMER_MODULE_B_CLK,
  input wire O_TIMER_MODULE_C_CLK,
  // Routed inputs
  input wire O_TMRA_CH0_IN,
  input wire O_SER0_RX,
  input wire [3:0] O_SPI0_IN,
  input wire I_I2C_FOUR_WIRE_ENABLE,
  input wire O_I2C_FOUR_WIRE_ACTIVE,
  input wire O_EXT_IRQ,
  input wire [7:0] I_PTA_IN,
  input wire [7:0] I_PTB_IN,
  input wire [7:0] I_PTE_IN,
  input wire [7:0] I_PTI_IN
);
  logic [31:0] sh_q;
  logic [1:0] age_q;
  wire up = age_q[1];
  wire rd_hit = I_RD && (I_ADDR == `PPS_OFF_PIN_SELECT_0);
  wire [2:0] tp = {I_EXT_TIMER_CLOCK_PIN_C, I_EXT_TIMER_CLOCK_PIN_B, I_EXT_TIMER_CLOCK_PIN_A};

  function automatic logic csel(input logic [1:0] s, input logic [2:0] p);
    csel = (s == 2'h3) ? 1'b0 : p[s];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Shadow of the register; age gates the first edges after reset
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      sh_q <= 32'h0;
      age_q <= 2'h0;
    end else begin
      if (I_WR && I_ADDR == `PPS_OFF_PIN_SELECT_0) begin
        sh_q <= I_WDATA & `PPS_WRITE_MASK;
      end
      if (!up) begin
        age_q <= age_q + 2'h1;
      end
    end
  end

  // Expected routing one flop ahead of the outputs
  wire [3:0] ck_d = {csel(sh_q[31:30], tp), csel(sh_q[29:28], tp), csel(sh_q[27:26], tp),
    csel(sh_q[25:24], tp)};
  wire a0_d = sh_q[8] ? I_PTB_IN[2] : I_PTA_IN[0];
  wire rx_d = sh_q[7] ? I_PTA_IN[2] : I_PTB_IN[0];
  wire [3:0] spi_d = sh_q[6] ? I_PTE_IN[3:0] : I_PTB_IN[5:2];
  wire irq_d = (sh_q[2:0] == 3'h0) ? I_PTA_IN[5] : I_PTI_IN[sh_q[2:0] - 3'h1];

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_SYS_RST);

  rd_answer_a: assert property (up && $past(rd_hit) |-> O_RDATA == $past(sh_q))
    else $error("read data differs from last write");
  rd_idle_a: assert property (up && !rd_hit |=> O_RDATA == 32'h0)
    else $error("read data not zero without a mapped read");
  rsvd_zero_a: assert property (O_RDATA[23:12] == 12'h0 && !O_RDATA[3])
    else $error("reserved bits read nonzero");
  pwt_clock_a: assert property (up |-> O_PULSE_WIDTH_TIMER_CLK == $past(ck_d[3]))
    else $error("pulse timer clock wrong");
  tmc_clock_a: assert property (up |-> O_TIMER_MODULE_C_CLK == $past(ck_d[2]))
    else $error("timer c clock wrong");
  tmb_clock_a: assert property (up |-> O_TIMER_MODULE_B_CLK == $past(ck_d[1]))
    else $error("timer b clock wrong");
  tma_clock_a: assert property (up |-> O_TIMER_MODULE_A_CLK == $past(ck_d[0]))
    else $error("timer a clock wrong");
  tma_ch0_a: assert property (up |-> O_TMRA_CH0_IN == $past(a0_d))
    else $error("timer a channel 0 input wrong");
  serial_rx_a: assert property (up |-> O_SER0_RX == $past(rx_d))
    else $error("serial receive input wrong");
  spi_in_a: assert property (up |-> O_SPI0_IN == $past(spi_d))
    else $error("spi inputs wrong");
  irq_route_a: assert property (up |-> O_EXT_IRQ == $past(irq_d))
    else $error("interrupt input wrong");
  four_wire_a: assert property (
    up && I_I2C_FOUR_WIRE_ENABLE && !sh_q[5] |=> O_I2C_FOUR_WIRE_ACTIVE)
    else $error("four wire option not active");

  cover property (I_WR ##2 rd_hit);
  cover property (up && sh_q[31:30] == 2'h3);
  cover property (O_EXT_IRQ && sh_q[2:0] == 3'h7);
endmodule

bind pps_top pps_monitor u_mon (.*);

// >>> dv/pps_top_tb.sv
// Self-checking testbench for the pin select block
`timescale 1ns/1ps
`include "pps_consts.vh"
module pps_top_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0, rd = 1'b0, run = 1'b0, tx = 1'b0, rtc = 1'b0, fw = 1'b0;
  logic [2:0] lvl = 3'h0;
  logic [3:0] tout = 4'h0, toe = 4'h0, spo = 4'h0, spe = 4'h0;
  logic [1:0] ico = 2'h0, ice = 2'h0;
  logic [47:0] pat = 48'h0;
  wire [31:0] rdata;
  wire [2:0] tclk;
  wire [3:0] clks, tin, spi;
  wire [1:0] ici;
  wire rx, fwa, irq;
  wire [47:0] pin, po, pe;
  // Pads taken by the second choice of every routed drive
  wire [11:0] alt_e = {pe[35:34], pe[10], pe[23], pe[19:16], pe[39:38], pe[29], pe[43]};
  wire [11:0] alt_o = {po[35:34], po[10], po[23], po[19:16], po[39:38], po[29], po[43]};
  int n_errors = 0;
  int n_checks = 0;
  localparam logic [7:0] OFF = `PPS_OFF_PIN_SELECT_0;

  pps_top uut (.I_MCLK(clk), .I_SYS_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_EXT_TIMER_CLOCK_PIN_A(tclk[0]),
    .I_EXT_TIMER_CLOCK_PIN_B(tclk[1]), .I_EXT_TIMER_CLOCK_PIN_C(tclk[2]),
    .O_PULSE_WIDTH_TIMER_CLK(clks[3]), .O_TIMER_MODULE_A_CLK(clks[0]),
    .O_TIMER_MODULE_B_CLK(clks[1]), .O_TIMER_MODULE_C_CLK(clks[2]),
    .I_TMRA_CH0_OUT(tout[0]), .I_TMRA_CH0_OE(toe[0]), .O_TMRA_CH0_IN(tin[0]),
    .I_TMRA_CH1_OUT(tout[1]), .I_TMRA_CH1_OE(toe[1]), .O_TMRA_CH1_IN(tin[1]),
    .I_TMRB_CH0_OUT(tout[2]), .I_TMRB_CH0_OE(toe[2]), .O_TMRB_CH0_IN(tin[2]),
    .I_TMRB_CH1_OUT(tout[3]), .I_TMRB_CH1_OE(toe[3]), .O_TMRB_CH1_IN(tin[3]),
    .I_SER0_TX(tx), .O_SER0_RX(rx), .I_SPI0_OUT(spo), .I_SPI0_OE(spe), .O_SPI0_IN(spi),
    .I_I2C0_OUT(ico), .I_I2C0_OE(ice), .O_I2C0_IN(ici), .I_I2C_FOUR_WIRE_ENABLE(fw),
    .O_I2C_FOUR_WIRE_ACTIVE(fwa), .I_REALTIME_COUNTER_OUTPUT(rtc), .O_EXT_IRQ(irq),
    .I_PTA_IN(pin[47:40]), .I_PTB_IN(pin[39:32]), .I_PTC_IN(pin[31:24]),
    .I_PTE_IN(pin[23:16]), .I_PTH_IN(pin[15:8]), .I_PTI_IN(pin[7:0]),
    .O_PTA_OUT(po[47:40]), .O_PTA_OE(pe[47:40]), .O_PTB_OUT(po[39:32]), .O_PTB_OE(pe[39:32]),
    .O_PTC_OUT(po[31:24]), .O_PTC_OE(pe[31:24]), .O_PTE_OUT(po[23:16]), .O_PTE_OE(pe[23:16]),
    .O_PTH_OUT(po[15:8]), .O_PTH_OE(pe[15:8]), .O_PTI_OUT(po[7:0]), .O_PTI_OE(pe[7:0]));

  pps_far_model u_far (.i_clk(clk), .i_run(run), .i_lvl(lvl), .i_out(po), .i_oe(pe),
    .i_pat(pat), .o_tclk(tclk), .o_in(pin));

  ////////////////////////////////////////////////////////////////////////
  // Shared bus cycles and comparison
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Route change needs the register edge plus the output flop
  task settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task t_regs;
    logic [31:0] d;
    rd_reg(OFF, d);
    chk(d, 32'h0);
    wr_reg(OFF, 32'hffffffff);
    rd_reg(OFF, d);
    chk(d, 32'hff000ff7);
    wr_reg(8'h10, 32'h0);
    rd_reg(OFF, d);
    chk(d, 32'hff000ff7);
    rd_reg(8'h10, d);
    chk(d, 32'h0);
    wr_reg(OFF, 32'h5a5a5a5a);
    rd_reg(OFF, d);
    chk(d, 32'h5a000a52);
  endtask

  // Each clock field, each code; a one-hot pin level shows which pin was taken
  task t_clk;
    for (int f = 0; f < 4; f++) begin
      for (int c = 0; c < 4; c++) begin
        lvl <= (c == 3) ? 3'h7 : (3'h1 << c);
        wr_reg(OFF, c << (24 + 2 * f));
        settle;
        chk(clks[f], (c != 3));
      end
    end
    run <= 1'b1;
    wr_reg(OFF, 32'h1b000000);
    repeat (20) @(posedge clk);
    wr_reg(OFF, 32'he4000000);
    repeat (20) @(posedge clk);
    run <= 1'b0;
  endtask

  // Pad inputs reach the peripherals through both settings of every bit
  task t_route;
    pat <= {8'h00, 8'hff, 8'h00, 8'h80, 8'hff, 8'h00};
    wr_reg(OFF, 32'h0);
    settle;
    chk({tin, rx, spi, ici}, {4'h0, 1'b1, 4'hf, 2'h0});
    wr_reg(OFF, 32'h00000ff0);
    settle;
    chk({tin, rx, spi, ici}, {4'hf, 1'b0, 4'h0, 2'h3});
  endtask

  // Peripheral drives land on the chosen pads only
  task t_drive;
    tout <= 4'h5;
    toe <= 4'hf;
    spo <= 4'h9;
    spe <= 4'hf;
    ico <= 2'h1;
    ice <= 2'h3;
    tx <= 1'b1;
    wr_reg(OFF, 32'h00000ff0);
    settle;
    chk(alt_e, 12'hfff);
    chk(alt_o, 12'h699);
    chk({pe[37:36], pe[7:0]}, 32'h0);
    wr_reg(OFF, 32'h0);
    settle;
    chk({pe[43:40], pe[37:32], pe[29:28]}, 12'hffb);
    chk({po[43:40], po[37:33], po[29:28]}, 11'h4cd);
    chk(pe[23:8], 32'h0);
    toe <= 4'h0;
    spe <= 4'h0;
    ice <= 2'h0;
    // With the channels quiet the counter output owns port C pin 4
    rtc <= 1'b1;
    wr_reg(OFF, 32'h0);
    settle;
    chk({pe[29:28], po[29:28]}, 4'h5);
  endtask

  // Every interrupt code, then a wrong pin high must not leak through
  task t_irq;
    for (int c = 0; c < 8; c++) begin
      pat <= {(c == 0) ? 8'h20 : 8'h00, 32'h0, (c == 0) ? 8'h00 : (8'h1 << (c - 1))};
      wr_reg(OFF, c);
      settle;
      chk(irq, 32'h1);
    end
    pat <= {8'h20, 32'h0, 8'hfe};
    wr_reg(OFF, 32'h1);
    settle;
    chk(irq, 32'h0);
  endtask

  task t_four;
    fw <= 1'b1;
    wr_reg(OFF, 32'h0);
    settle;
    chk(fwa, 32'h1);
    wr_reg(OFF, 32'h20);
    settle;
    chk(fwa, 32'h0);
    fw <= 1'b0;
    wr_reg(OFF, 32'h0);
    settle;
    chk(fwa, 32'h0);
  endtask

  task end_sim;
    if (n_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    n_errors++;
    end_sim;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_clk;
    t_route;
    t_drive;
    t_irq;
    t_four;
    end_sim;
  end
endmodule

// >>> rtl/pps_clk_sel.v
// External timer clock pin selector with a registered output
`timescale 1ns/1ps
`include "pps_consts.vh"
module pps_clk_sel (
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // Select and candidate pins
  input wire [1:0] i_sel,
  input wire i_pin_a,
  input wire i_pin_b,
  input wire i_pin_c,
  // Selected clock
  output reg o_clk_sel
);

  reg clk_d;

  // Reserved code leaves the timer with no clock rather than a stray pin
  always @* begin
    case (i_sel)
      `PPS_CLK_SEL_PIN_A: clk_d = i_pin_a;
      `PPS_CLK_SEL_PIN_B: clk_d = i_pin_b;
      `PPS_CLK_SEL_PIN_C: clk_d = i_pin_c;
      default: clk_d = 1'b0;
    endcase
  end

  // Output flop
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_clk_sel <= 1'b0;
    end else begin
      o_clk_sel <= clk_d;
    end
  end

endmodule

// >>> rtl/pps_consts.vh
// Constants for the peripheral pin select block: offsets, fields, resets and pad positions
`ifndef PPS_CONSTS_VH
`define PPS_CONSTS_VH

// Register bus
`define PPS_ADDR_W 8
`define PPS_OFF_PIN_SELECT_0 8'h0c
`define PPS_RESET_PIN_SELECT_0 32'h00000000
`define PPS_WRITE_MASK 32'hff000ff7
`define PPS_RDATA_IDLE 32'h00000000

// Field positions of peripheral_pin_select_0
`define PPS_PULSE_TIMER_CLOCK_SELECT_HI 31
`define PPS_PULSE_TIMER_CLOCK_SELECT_LO 30
`define PPS_TIMER2_CLOCK_SELECT_HI 29
`define PPS_TIMER2_CLOCK_SELECT_LO 28
`define PPS_TIMER1_CLOCK_SELECT_HI 27
`define PPS_TIMER1_CLOCK_SELECT_LO 26
`define PPS_TIMER0_CLOCK_SELECT_HI 25
`define PPS_TIMER0_CLOCK_SELECT_LO 24
`define PPS_TIMER1_CH1_PIN_SELECT 11
`define PPS_TIMER1_CH0_PIN_SELECT 10
`define PPS_TIMER0_CH1_PIN_SELECT 9
`define PPS_TIMER0_CH0_PIN_SELECT 8
`define PPS_SERIAL0_PIN_SELECT 7
`define PPS_SPI_PORT0_PIN_SELECT 6
`define PPS_I2C_PORT0_PIN_SELECT 5
`define PPS_REALTIME_OUT_PIN_SELECT 4
`define PPS_EXT_INTERRUPT_PIN_SELECT_HI 2
`define PPS_EXT_INTERRUPT_PIN_SELECT_LO 0

// Clock select codes
`define PPS_CLK_SEL_PIN_A 2'h0
`define PPS_CLK_SEL_PIN_B 2'h1
`define PPS_CLK_SEL_PIN_C 2'h2

// Interrupt select code that picks the port A pin
`define PPS_IRQ_SEL_PORT_A 3'h0

// Pad positions within each port
`define PPS_PAD_T0C0_A 0
`define PPS_PAD_T0C1_A 1
`define PPS_PAD_SER_RX_B 0
`define PPS_PAD_SER_TX_B 1
`define PPS_PAD_SER_RX_A 2
`define PPS_PAD_SER_TX_A 3
`define PPS_PAD_I2C_SCL_A 3
`define PPS_PAD_I2C_SDA_A 2
`define PPS_PAD_I2C_SCL_B 7
`define PPS_PAD_I2C_SDA_B 6
`define PPS_PAD_IRQ_A 5
`define PPS_PAD_T0C0_B 2
`define PPS_PAD_T0C1_B 3
`define PPS_PAD_SPI_B0 2
`define PPS_PAD_SPI_E0 0
`define PPS_PAD_T1C0_C 4
`define PPS_PAD_T1C1_C 5
`define PPS_PAD_RTC_C0 4
`define PPS_PAD_RTC_C1 5
`define PPS_PAD_T1C1_E 7
`define PPS_PAD_T1C0_H 2

`endif

// >>> rtl/pps_pin_pair.v
// Routes one peripheral signal to one of two candidate pads
`timescale 1ns/1ps
module pps_pin_pair (
  // Select
  input wire i_sel,
  // Peripheral side
  input wire i_sig_out,
  input wire i_sig_oe,
  output wire o_sig_in,
  // Pad side
  input wire i_pad0_in,
  input wire i_pad1_in,
  output wire o_pad0_out,
  output wire o_pad0_oe,
  output wire o_pad1_out,
  output wire o_pad1_oe
);

  // Only the chosen pad is driven; the other stays released
  assign o_pad0_out = ~i_sel & i_sig_out;
  assign o_pad0_oe = ~i_sel & i_sig_oe;
  assign o_pad1_out = i_sel & i_sig_out;
  assign o_pad1_oe = i_sel & i_sig_oe;
  assign o_sig_in = i_sel ? i_pad1_in : i_pad0_in;

endmodule

// >>> rtl/pps_top.v
// Peripheral pin select register and pad routing top level
//
// Contract
// - Bits 31:30 pick the pulse width timer clock from pin a, b or c, code 3 reserved.
// - Bits 29:28 pick timer module c's clock with the same code.
// - Bits 27:26 pick timer module b's clock with the same code.
// - Bits 25:24 pick timer module a's clock with the same code.
// - Bits 23:12 and bit 3 always read zero whatever is written.
// - Bit 11 puts timer b channel 1 on port C pin 5 or port E pin 7.
// - Bit 10 puts timer b channel 0 on port C pin 4 or port H pin 2.
// - Bit 9 puts timer a channel 1 on port A pin 1 or port B pin 3.
// - Bit 8 puts timer a channel 0 on port A pin 0 or port B pin 2.
// - Bit 7 puts serial receive and transmit on port B pins 0,1 or port A pins 2,3.
// - Bit 6 puts SPI clock, MOSI, MISO and select on port B pins 2-5 or port E pins 0-3.
// - Bit 5 puts I2C SCL, SDA on port A pins 3,2 or port B pins 7,6.
// - Bit 4 puts the real time counter output on port C pin 4 or pin 5.
// - Bits 2:0 take the interrupt from port A pin 5 for 0, else port I pin code minus one.
// - The I2C four wire option is active only while the I2C pin select bit is 0.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "pps_consts.vh"
module pps_top (
  // Clock and reset
  input wire I_MCLK,
  input wire I_SYS_RST,
  // Register port
  input wire [7:0] I_ADDR,
  input wire [31:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  output reg [31:0] O_RDATA,
  // External timer clock pins
  input wire I_EXT_TIMER_CLOCK_PIN_A,
  input wire I_EXT_TIMER_CLOCK_PIN_B,
  input wire I_EXT_TIMER_CLOCK_PIN_C,
  // Selected timer clocks
  output wire O_PULSE_WIDTH_TIMER_CLK,
  output wire O_TIMER_MODULE_A_CLK,
  output wire O_TIMER_MODULE_B_CLK,
  output wire O_TIMER_MODULE_C_CLK,
  // Timer channels
  input wire I_TMRA_CH0_OUT,
  input wire I_TMRA_CH0_OE,
  output reg O_TMRA_CH0_IN,
  input wire I_TMRA_CH1_OUT,
  input wire I_TMRA_CH1_OE,
  output reg O_TMRA_CH1_IN,
  input wire I_TMRB_CH0_OUT,
  input wire I_TMRB_CH0_OE,
  output reg O_TMRB_CH0_IN,
  input wire I_TMRB_CH1_OUT,
  input wire I_TMRB_CH1_OE,
  output reg O_TMRB_CH1_IN,
  // Serial port 0
  input wire I_SER0_TX,
  output reg O_SER0_RX,
  // SPI port 0
  input wire [3:0] I_SPI0_OUT,
  input wire [3:0] I_SPI0_OE,
  output reg [3:0] O_SPI0_IN,
  // I2C port 0, index 0 SCL, index 1 SDA
  input wire [1:0] I_I2C0_OUT,
  input wire [1:0] I_I2C0_OE,
  output reg [1:0] O_I2C0_IN,
  input wire I_I2C_FOUR_WIRE_ENABLE,
  output reg O_I2C_FOUR_WIRE_ACTIVE,
  // Real time counter and external interrupt
  input wire I_REALTIME_COUNTER_OUTPUT,
  output reg O_EXT_IRQ,
  // Port pads
  input wire [7:0] I_PTA_IN,
  input wire [7:0] I_PTB_IN,
  input wire [7:0] I_PTC_IN,
  input wire [7:0] I_PTE_IN,
  input wire [7:0] I_PTH_IN,
  input wire [7:0] I_PTI_IN,
  output reg [7:0] O_PTA_OUT,
  output reg [7:0] O_PTA_OE,
  output reg [7:0] O_PTB_OUT,
  output reg [7:0] O_PTB_OE,
  output reg [7:0] O_PTC_OUT,
  output reg [7:0] O_PTC_OE,
  output reg [7:0] O_PTE_OUT,
  output reg [7:0] O_PTE_OE,
  output reg [7:0] O_PTH_OUT,
  output reg [7:0] O_PTH_OE,
  output reg [7:0] O_PTI_OUT,
  output reg [7:0] O_PTI_OE
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register port

  reg [31:0] sel_q;
  reg [31:0] sel_d;
  reg [31:0] rdata_d;
  wire hit;

  assign hit = (I_ADDR == `PPS_OFF_PIN_SELECT_0);

  // Write path; masking keeps reserved bits at zero in storage
  always @* begin
    sel_d = sel_q;
    if (I_WR && hit) begin
      sel_d = I_WDATA & `PPS_WRITE_MASK;
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped reads give zero
  always @* begin
    rdata_d = `PPS_RDATA_IDLE;
    if (I_RD && hit) begin
      rdata_d = sel_q & `PPS_WRITE_MASK;
    end
  end

  // Register flops
  always @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      sel_q <= `PPS_RESET_PIN_SELECT_0;
      O_RDATA <= `PPS_RDATA_IDLE;
    end else begin
      sel_q <= sel_d;
      O_RDATA <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Timer clock selection

  // Pulse width timer clock
  pps_clk_sel u_clk_pwt (
    .i_clk(I_MCLK),
    .i_rst(I_SYS_RST),
    .i_sel(sel_q[`PPS_PULSE_TIMER_CLOCK_SELECT_HI:`PPS_PULSE_TIMER_CLOCK_SELECT_LO]),
    .i_pin_a(I_EXT_TIMER_CLOCK_PIN_A),
    .i_pin_b(I_EXT_TIMER_CLOCK_PIN_B),
    .i_pin_c(I_EXT_TIMER_CLOCK_PIN_C),
    .o_clk_sel(O_PULSE_WIDTH_TIMER_CLK)
  );

  // Timer module c clock
  pps_clk_sel u_clk_tc (
    .i_clk(I_MCLK),
    .i_rst(I_SYS_RST),
    .i_sel(sel_q[`PPS_TIMER2_CLOCK_SELECT_HI:`PPS_TIMER2_CLOCK_SELECT_LO]),
    .i_pin_a(I_EXT_TIMER_CLOCK_PIN_A),
    .i_pin_b(I_EXT_TIMER_CLOCK_PIN_B),
    .i_pin_c(I_EXT_TIMER_CLOCK_PIN_C),
    .o_clk_sel(O_TIMER_MODULE_C_CLK)
  );

  // Timer module b clock
  pps_clk_sel u_clk_tb (
    .i_clk(I_MCLK),
    .i_rst(I_SYS_RST),
    .i_sel(sel_q[`PPS_TIMER1_CLOCK_SELECT_HI:`PPS_TIMER1_CLOCK_SELECT_LO]),
    .i_pin_a(I_EXT_TIMER_CLOCK_PIN_A),
    .i_pin_b(I_EXT_TIMER_CLOCK_PIN_B),
    .i_pin_c(I_EXT_TIMER_CLOCK_PIN_C),
    .o_clk_sel(O_TIMER_MODULE_B_CLK)
  );

  // Timer module a clock
  pps_clk_sel u_clk_ta (
    .i_clk(I_MCLK),
    .i_rst(I_SYS_RST),
    .i_sel(sel_q[`PPS_TIMER0_CLOCK_SELECT_HI:`PPS_TIMER0_CLOCK_SELECT_LO]),
    .i_pin_a(I_EXT_TIMER_CLOCK_PIN_A),
    .i_pin_b(I_EXT_TIMER_CLOCK_PIN_B),
    .i_pin_c(I_EXT_TIMER_CLOCK_PIN_C),
    .o_clk_sel(O_TIMER_MODULE_A_CLK)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Signal routing; index 0..3 timer channels, 4 serial rx, 5 serial tx,
  // 6..9 SPI, 10 SCL, 11 SDA, 12 real time output

  localparam NPAIR = 13;

  wire [NPAIR-1:0] p_sel;
  wire [NPAIR-1:0] p_out;
  wire [NPAIR-1:0] p_oe;
  wire [NPAIR-1:0] p_in0;
  wire [NPAIR-1:0] p_in1;
  wire [NPAIR-1:0] p_sig_in;
  wire [NPAIR-1:0] p_o0;
  wire [NPAIR-1:0] p_e0;
  wire [NPAIR-1:0] p_o1;
  wire [NPAIR-1:0] p_e1;

  // Select bit of each routed signal
  assign p_sel[0] = sel_q[`PPS_TIMER0_CH0_PIN_SELECT];
  assign p_sel[1] = sel_q[`PPS_TIMER0_CH1_PIN_SELECT];
  assign p_sel[2] = sel_q[`PPS_TIMER1_CH0_PIN_SELECT];
  assign p_sel[3] = sel_q[`PPS_TIMER1_CH1_PIN_SELECT];
  assign p_sel[5:4] = {2{sel_q[`PPS_SERIAL0_PIN_SELECT]}};
  assign p_sel[9:6] = {4{sel_q[`PPS_SPI_PORT0_PIN_SELECT]}};
  assign p_sel[11:10] = {2{sel_q[`PPS_I2C_PORT0_PIN_SELECT]}};
  assign p_sel[12] = sel_q[`PPS_REALTIME_OUT_PIN_SELECT];

  // Peripheral drive; receive is input only, transmit and counter output always drive
  assign p_out = {I_REALTIME_COUNTER_OUTPUT, I_I2C0_OUT, I_SPI0_OUT, I_SER0_TX, 1'b0,
                  I_TMRB_CH1_OUT, I_TMRB_CH0_OUT, I_TMRA_CH1_OUT, I_TMRA_CH0_OUT};
  assign p_oe = {1'b1, I_I2C0_OE, I_SPI0_OE, 1'b1, 1'b0,
                 I_TMRB_CH1_OE, I_TMRB_CH0_OE, I_TMRA_CH1_OE, I_TMRA_CH0_OE};

  // Pad inputs seen by each pair, first and second choice
  assign p_in0 = {I_PTC_IN[`PPS_PAD_RTC_C0],
                  I_PTA_IN[`PPS_PAD_I2C_SDA_A], I_PTA_IN[`PPS_PAD_I2C_SCL_A],
                  I_PTB_IN[`PPS_PAD_SPI_B0+3:`PPS_PAD_SPI_B0],
                  I_PTB_IN[`PPS_PAD_SER_TX_B], I_PTB_IN[`PPS_PAD_SER_RX_B],
                  I_PTC_IN[`PPS_PAD_T1C1_C], I_PTC_IN[`PPS_PAD_T1C0_C],
                  I_PTA_IN[`PPS_PAD_T0C1_A], I_PTA_IN[`PPS_PAD_T0C0_A]};
  assign p_in1 = {I_PTC_IN[`PPS_PAD_RTC_C1],
                  I_PTB_IN[`PPS_PAD_I2C_SDA_B], I_PTB_IN[`PPS_PAD_I2C_SCL_B],
                  I_PTE_IN[`PPS_PAD_SPI_E0+3:`PPS_PAD_SPI_E0],
                  I_PTA_IN[`PPS_PAD_SER_TX_A], I_PTA_IN[`PPS_PAD_SER_RX_A],
                  I_PTE_IN[`PPS_PAD_T1C1_E], I_PTH_IN[`PPS_PAD_T1C0_H],
                  I_PTB_IN[`PPS_PAD_T0C1_B], I_PTB_IN[`PPS_PAD_T0C0_B]};

  // One two-way router per signal
  genvar gi;
  generate
    for (gi = 0; gi < NPAIR; gi = gi + 1) begin : g_pair
      pps_pin_pair u_pair (
        .i_sel(p_sel[gi]),
        .i_sig_out(p_out[gi]),
        .i_sig_oe(p_oe[gi]),
        .o_sig_in(p_sig_in[gi]),
        .i_pad0_in(p_in0[gi]),
        .i_pad1_in(p_in1[gi]),
        .o_pad0_out(p_o0[gi]),
        .o_pad0_oe(p_e0[gi]),
        .o_pad1_out(p_o1[gi]),
        .o_pad1_oe(p_e1[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Pad merge

  // Lays one driver over a pad's {oe,out}; a driving source replaces what was there
  function [1:0] mrg;
    input [1:0] cur;
    input o;
    input e;
    begin
      mrg = e ? {1'b1, o} : cur;
    end
  endfunction

  reg [7:0] pa_o, pa_e, pb_o, pb_e, pc_o, pc_e, pe_o, pe_e, ph_o, ph_e;

  // Shared pads: later lines win, so timer channels override SPI and the counter output,
  // and I2C overrides serial transmit, when software selects both onto one pin
  always @* begin
    pa_o = 8'h00;
    pa_e = 8'h00;
    pb_o = 8'h00;
    pb_e = 8'h00;
    pc_o = 8'h00;
    pc_e = 8'h00;
    pe_o = 8'h00;
    pe_e = 8'h00;
    ph_o = 8'h00;
    ph_e = 8'h00;
    // Serial port
    {pb_e[`PPS_PAD_SER_TX_B], pb_o[`PPS_PAD_SER_TX_B]} =
      mrg({pb_e[`PPS_PAD_SER_TX_B], pb_o[`PPS_PAD_SER_TX_B]}, p_o0[5], p_e0[5]);
    {pa_e[`PPS_PAD_SER_TX_A], pa_o[`PPS_PAD_SER_TX_A]} =
      mrg({pa_e[`PPS_PAD_SER_TX_A], pa_o[`PPS_PAD_SER_TX_A]}, p_o1[5], p_e1[5]);
    // SPI port
    {pb_e[`PPS_PAD_SPI_B0+0], pb_o[`PPS_PAD_SPI_B0+0]} = {p_e0[6], p_o0[6]};
    {pb_e[`PPS_PAD_SPI_B0+1], pb_o[`PPS_PAD_SPI_B0+1]} = {p_e0[7], p_o0[7]};
    {pb_e[`PPS_PAD_SPI_B0+2], pb_o[`PPS_PAD_SPI_B0+2]} = {p_e0[8], p_o0[8]};
    {pb_e[`PPS_PAD_SPI_B0+3], pb_o[`PPS_PAD_SPI_B0+3]} = {p_e0[9], p_o0[9]};
    {pe_e[`PPS_PAD_SPI_E0+3:`PPS_PAD_SPI_E0]} = p_e1[9:6];
    {pe_o[`PPS_PAD_SPI_E0+3:`PPS_PAD_SPI_E0]} = p_o1[9:6];
    // I2C port
    {pa_e[`PPS_PAD_I2C_SCL_A], pa_o[`PPS_PAD_I2C_SCL_A]} =
      mrg({pa_e[`PPS_PAD_I2C_SCL_A], pa_o[`PPS_PAD_I2C_SCL_A]}, p_o0[10], p_e0[10]);
    {pa_e[`PPS_PAD_I2C_SDA_A], pa_o[`PPS_PAD_I2C_SDA_A]} =
      mrg({pa_e[`PPS_PAD_I2C_SDA_A], pa_o[`PPS_PAD_I2C_SDA_A]}, p_o0[11], p_e0[11]);
    {pb_e[`PPS_PAD_I2C_SCL_B], pb_o[`PPS_PAD_I2C_SCL_B]} = {p_e1[10], p_o1[10]};
    {pb_e[`PPS_PAD_I2C_SDA_B], pb_o[`PPS_PAD_I2C_SDA_B]} = {p_e1[11], p_o1[11]};
    // Real time counter output
    {pc_e[`PPS_PAD_RTC_C0], pc_o[`PPS_PAD_RTC_C0]} = {p_e0[12], p_o0[12]};
    {pc_e[`PPS_PAD_RTC_C1], pc_o[`PPS_PAD_RTC_C1]} = {p_e1[12], p_o1[12]};
    // Timer channels
    {pa_e[`PPS_PAD_T0C0_A], pa_o[`PPS_PAD_T0C0_A]} = {p_e0[0], p_o0[0]};
    {pb_e[`PPS_PAD_T0C0_B], pb_o[`PPS_PAD_T0C0_B]} =
      mrg({pb_e[`PPS_PAD_T0C0_B], pb_o[`PPS_PAD_T0C0_B]}, p_o1[0], p_e1[0]);
    {pa_e[`PPS_PAD_T0C1_A], pa_o[`PPS_PAD_T0C1_A]} = {p_e0[1], p_o0[1]};
    {pb_e[`PPS_PAD_T0C1_B], pb_o[`PPS_PAD_T0C1_B]} =
      mrg({pb_e[`PPS_PAD_T0C1_B], pb_o[`PPS_PAD_T0C1_B]}, p_o1[1], p_e1[1]);
    {pc_e[`PPS_PAD_T1C0_C], pc_o[`PPS_PAD_T1C0_C]} =
      mrg({pc_e[`PPS_PAD_T1C0_C], pc_o[`PPS_PAD_T1C0_C]}, p_o0[2], p_e0[2]);
    {ph_e[`PPS_PAD_T1C0_H], ph_o[`PPS_PAD_T1C0_H]} = {p_e1[2], p_o1[2]};
    {pc_e[`PPS_PAD_T1C1_C], pc_o[`PPS_PAD_T1C1_C]} =
      mrg({pc_e[`PPS_PAD_T1C1_C], pc_o[`PPS_PAD_T1C1_C]}, p_o0[3], p_e0[3]);
    {pe_e[`PPS_PAD_T1C1_E], pe_o[`PPS_PAD_T1C1_E]} = {p_e1[3], p_o1[3]};
  end

  ////////////////////////////////////////////////////////////////////////////////
  // External interrupt and four wire option

  reg irq_d;
  wire [2:0] irq_sel;

  assign irq_sel = sel_q[`PPS_EXT_INTERRUPT_PIN_SELECT_HI:`PPS_EXT_INTERRUPT_PIN_SELECT_LO];

  // Code 0 takes port A; codes 1 to 7 take port I pins 0 to 6
  always @* begin
    if (irq_sel == `PPS_IRQ_SEL_PORT_A) begin
      irq_d = I_PTA_IN[`PPS_PAD_IRQ_A];
    end else begin
      irq_d = I_PTI_IN[irq_sel - 3'h1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output flops; every routed value costs one cycle of latency so that all
  // outputs come from flops, which limits pass-through of fast pad toggles

  always @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_TMRA_CH0_IN <= 1'b0;
      O_TMRA_CH1_IN <= 1'b0;
      O_TMRB_CH0_IN <= 1'b0;
      O_TMRB_CH1_IN <= 1'b0;
      O_SER0_RX <= 1'b0;
      O_SPI0_IN <= 4'h0;
      O_I2C0_IN <= 2'h0;
      O_I2C_FOUR_WIRE_ACTIVE <= 1'b0;
      O_EXT_IRQ <= 1'b0;
      O_PTA_OUT <= 8'h00;
      O_PTA_OE <= 8'h00;
      O_PTB_OUT <= 8'h00;
      O_PTB_OE <= 8'h00;
      O_PTC_OUT <= 8'h00;
      O_PTC_OE <= 8'h00;
      O_PTE_OUT <= 8'h00;
      O_PTE_OE <= 8'h00;
      O_PTH_OUT <= 8'h00;
      O_PTH_OE <= 8'h00;
      O_PTI_OUT <= 8'h00;
      O_PTI_OE <= 8'h00;
    end else begin
      O_TMRA_CH0_IN <= p_sig_in[0];
      O_TMRA_CH1_IN <= p_sig_in[1];
      O_TMRB_CH0_IN <= p_sig_in[2];
      O_TMRB_CH1_IN <= p_sig_in[3];
      O_SER0_RX <= p_sig_in[4];
      O_SPI0_IN <= p_sig_in[9:6];
      O_I2C0_IN <= p_sig_in[11:10];
      O_I2C_FOUR_WIRE_ACTIVE <= I_I2C_FOUR_WIRE_ENABLE &
                                ~sel_q[`PPS_I2C_PORT0_PIN_SELECT];
      O_EXT_IRQ <= irq_d;
      O_PTA_OUT <= pa_o;
      O_PTA_OE <= pa_e;
      O_PTB_OUT <= pb_o;
      O_PTB_OE <= pb_e;
      O_PTC_OUT <= pc_o;
      O_PTC_OE <= pc_e;
      O_PTE_OUT <= pe_o;
      O_PTE_OE <= pe_e;
      O_PTH_OUT <= ph_o;
      O_PTH_OE <= ph_e;
      O_PTI_OUT <= 8'h00; // Port I pins are inputs only here
      O_PTI_OE <= 8'h00;
    end
  end

endmodule
